// [aob_device.sv]
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module aob_device #(
	parameter int CH_AVAIL = 16
) (
	input wire logic clk,
	input wire logic rst,
	aob_if.dev bus,
	input wire logic ext_clk_pin,
	input wire logic trig_pin,
	output logic [aob_pkg::NUM_CH*aob_pkg::SAMPLE_W-1:0] chan_out,
	output logic [aob_pkg::NUM_CH-1:0] chan_update
);
	typedef enum logic [1:0] {AOB_IDLE, AOB_FILL, AOB_COMMIT} aob_state_t;

	// Next active channel above cur, wrapping to the lowest
	function automatic logic [aob_pkg::CH_IDX_W-1:0] aob_next_ch(
		input logic [aob_pkg::NUM_CH-1:0] m, input logic [aob_pkg::CH_IDX_W-1:0] cur);
		logic [aob_pkg::CH_IDX_W-1:0] res;
		logic found;
		res = cur;
		found = 1'b0;
		for (int i = aob_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (m[i] && !found) begin
				res = aob_pkg::CH_IDX_W'(i);
			end
		end
		for (int i = aob_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (m[i] && i > int'(cur)) begin
				res = aob_pkg::CH_IDX_W'(i);
				found = 1'b1;
			end
		end
		return res;
	endfunction : aob_next_ch

	logic [aob_pkg::WORD_W-1:0] mem [0:aob_pkg::FIFO_DEPTH-1];
	logic [aob_pkg::PTR_W-1:0] wr_ptr_reg;
	logic [aob_pkg::PTR_W-1:0] rd_ptr_reg;
	logic [aob_pkg::CNT_W-1:0] count_reg;
	logic [aob_pkg::NUM_CH-1:0] mask_reg;
	logic [4:0] ctl_reg;
	logic [3:0] size_reg;
	logic ext_sel_reg, clk_en_reg, sw_clk_reg, circ_reg, ovf_reg;
	logic [aob_pkg::RATE_W-1:0] rate_reg;
	logic [aob_pkg::RATE_W-1:0] div_reg;
	logic [2:0] ext_sync_reg, trig_sync_reg;
	logic ext_lvl_reg, trig_lvl_reg;
	logic armed_reg, eof_seen_reg;
	aob_state_t state_reg;
	logic [aob_pkg::CH_IDX_W-1:0] ch_reg;
	logic [aob_pkg::SAMPLE_W-1:0] shadow [0:aob_pkg::NUM_CH-1];
	logic [aob_pkg::SAMPLE_W-1:0] out_reg [0:aob_pkg::NUM_CH-1];
	logic [aob_pkg::NUM_CH-1:0] upd_reg;
	logic [aob_pkg::DATA_W-1:0] rdata_reg;
	logic soft_init;
	logic [aob_pkg::NUM_CH-1:0] avail_mask, act_mask;
	logic [aob_pkg::CNT_W-1:0] cap;
	logic flag_empty, flag_low, flag_high, flag_full;
	logic ext_rise, trig_rise, int_tick, tick, run;
	logic pop, push, host_push, recirc, host_wr_data, seq_mode;
	logic [aob_pkg::WORD_W-1:0] head;
	logic [aob_pkg::SAMPLE_W-1:0] conv;
	logic [aob_pkg::CH_IDX_W-1:0] first_ch, nxt_ch;
	logic last_in_group;
	logic buf_clear;
	logic [aob_pkg::DATA_W-1:0] bor_view, rd_mux;

	// Variant mask and effective active channels
	// variant channel limit
	assign avail_mask = aob_pkg::NUM_CH'((32'h1 << CH_AVAIL) - 32'h1);
	assign act_mask = mask_reg & avail_mask;
	assign first_ch = aob_next_ch(act_mask, aob_pkg::CH_IDX_W'(aob_pkg::NUM_CH - 1));
	assign nxt_ch = aob_next_ch(act_mask, ch_reg);
	assign last_in_group = nxt_ch <= ch_reg;
	assign soft_init = ctl_reg[aob_pkg::CTL_INIT];

	// Active buffer capacity and status flags
	// programmable size
	assign cap = aob_pkg::CNT_W'(1) << (5'(size_reg) + 5'(aob_pkg::SIZE_BASE));
	assign flag_empty = count_reg == '0;
	assign flag_low = count_reg < (cap >> 2);
	assign flag_high = count_reg > (cap - (cap >> 2));
	assign flag_full = count_reg >= cap;

	// Sample clock source
	// clock source select
	assign ext_rise = ext_sync_reg[2] && ext_sync_reg[1] && !ext_lvl_reg;
	assign trig_rise = trig_sync_reg[2] && trig_sync_reg[1] && !trig_lvl_reg;
	assign int_tick = div_reg == '0;
	assign tick = clk_en_reg && (ext_sel_reg ? (ext_rise || sw_clk_reg) : int_tick);
	assign run = ctl_reg[aob_pkg::CTL_BURST] ? armed_reg : 1'b1;
	assign seq_mode = !ctl_reg[aob_pkg::CTL_SIMUL];

	// Buffer pop, recirculation and host push
	assign head = mem[rd_ptr_reg];
	assign pop = !flag_empty && act_mask != '0 && run &&
		(seq_mode ? tick : (state_reg == AOB_FILL));
	assign recirc = pop && circ_reg;
	assign host_wr_data = bus.bus_wr && bus.bus_addr == aob_pkg::OFF_SAMPLE;
	// Clear pulse also parks the sequencer so no stale group commits later
	assign buf_clear = bus.bus_wr && bus.bus_addr == aob_pkg::OFF_BUF_OPS && bus.bus_wdata[aob_pkg::BOR_CLEAR];
	assign host_push = host_wr_data && !flag_full && !recirc;
	assign push = recirc || host_push;

	assign conv = ctl_reg[aob_pkg::CTL_OFFSET_BIN] ? head[aob_pkg::SAMPLE_W-1:0] :
		{~head[aob_pkg::SIGN_BIT], head[aob_pkg::SIGN_BIT-1:0]};

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= recirc ? head : bus.bus_wdata[aob_pkg::WORD_W-1:0];
		end
	end

	// FIFO pointers and fill count
	always_ff @(posedge clk) begin
		if (rst || soft_init || buf_clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + aob_pkg::PTR_W'(push);
			rd_ptr_reg <= rd_ptr_reg + aob_pkg::PTR_W'(pop);
			count_reg <= count_reg + aob_pkg::CNT_W'(push) - aob_pkg::CNT_W'(pop);
		end
	end

	// Pin synchronisers, three stages, change taken when last two agree
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_sync_reg <= '0;
			trig_sync_reg <= '0;
			ext_lvl_reg <= 1'b0;
			trig_lvl_reg <= 1'b0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_pin};
			trig_sync_reg <= {trig_sync_reg[1:0], trig_pin};
			if (ext_sync_reg[2] == ext_sync_reg[1]) begin
				ext_lvl_reg <= ext_sync_reg[2];
			end
			if (trig_sync_reg[2] == trig_sync_reg[1]) begin
				trig_lvl_reg <= trig_sync_reg[2];
			end
		end
	end

	// Register writes
	// channel mask register
	always_ff @(posedge clk) begin
		if (rst || soft_init) begin
			mask_reg <= aob_pkg::CHAN_MASK_RST[aob_pkg::NUM_CH-1:0];
			ctl_reg <= 5'(1 << aob_pkg::CTL_OFFSET_BIN);
			size_reg <= aob_pkg::SIZE_RST;
			{ext_sel_reg, clk_en_reg, sw_clk_reg, circ_reg, ovf_reg} <= '0;
			rate_reg <= aob_pkg::RATE_RST;
		end else begin
			if (tick || !ext_sel_reg) begin
				sw_clk_reg <= 1'b0;
			end
			ctl_reg[aob_pkg::CTL_TRIG_SW] <= 1'b0;
			if (bus.bus_wr) begin
				case (bus.bus_addr)
					aob_pkg::OFF_CONTROL: ctl_reg <= bus.bus_wdata[4:0];
					aob_pkg::OFF_CHAN_MASK: mask_reg <= bus.bus_wdata[aob_pkg::NUM_CH-1:0];
					aob_pkg::OFF_RATE: rate_reg <= bus.bus_wdata[aob_pkg::RATE_W-1:0];
					aob_pkg::OFF_BUF_OPS: begin
						size_reg <= bus.bus_wdata[3:0];
						ext_sel_reg <= bus.bus_wdata[aob_pkg::BOR_EXT_CLK];
						clk_en_reg <= bus.bus_wdata[aob_pkg::BOR_CLK_EN];
						sw_clk_reg <= bus.bus_wdata[aob_pkg::BOR_SW_CLK];
						circ_reg <= bus.bus_wdata[aob_pkg::BOR_CIRC];
						ovf_reg <= bus.bus_wdata[aob_pkg::BOR_OVERFLOW];
					end
					default: ;
				endcase
			end
			if (host_wr_data && flag_full) begin
				ovf_reg <= 1'b1;
			end
		end
	end

	// Internal rate divider
	always_ff @(posedge clk) begin
		if (rst || soft_init || int_tick) begin
			div_reg <= rate_reg;
		end else begin
			div_reg <= div_reg - aob_pkg::RATE_W'(1);
		end
	end

	// Burst arming and group sequencing
	always_ff @(posedge clk) begin
		if (rst || soft_init || buf_clear) begin
			armed_reg <= 1'b0;
			eof_seen_reg <= 1'b0;
			state_reg <= AOB_IDLE;
			ch_reg <= aob_pkg::CH_IDX_W'(aob_pkg::NUM_CH - 1);
		end else begin
			if (!armed_reg && (trig_rise || ctl_reg[aob_pkg::CTL_TRIG_SW])) begin
				armed_reg <= 1'b1;
				eof_seen_reg <= 1'b0;
			end else if (pop && head[aob_pkg::EOF_BIT]) begin
				eof_seen_reg <= 1'b1;
				if (seq_mode) begin
					armed_reg <= 1'b0;
				end
			end
			case (state_reg)
				AOB_IDLE: begin
					if (!seq_mode && tick && run && act_mask != '0) begin
						state_reg <= AOB_FILL;
						ch_reg <= first_ch;
					end else if (seq_mode && pop) begin
						ch_reg <= nxt_ch;
					end
				end
				AOB_FILL: begin
					if (pop) begin
						ch_reg <= nxt_ch;
						if (last_in_group) begin
							state_reg <= AOB_COMMIT;
						end
					end
				end
				AOB_COMMIT: begin
					state_reg <= AOB_IDLE;
					if (eof_seen_reg) begin
						armed_reg <= 1'b0;
					end
					ch_reg <= aob_pkg::CH_IDX_W'(aob_pkg::NUM_CH - 1);
				end
				default: state_reg <= AOB_IDLE;
			endcase
		end
	end

	// Per-channel output latches
	genvar g;
	generate
		for (g = 0; g < aob_pkg::NUM_CH; g++) begin : g_ch
			always_ff @(posedge clk) begin
				if (rst || soft_init) begin
					out_reg[g] <= aob_pkg::MIDRANGE;
					shadow[g] <= aob_pkg::MIDRANGE;
					upd_reg[g] <= 1'b0;
				end else begin
					upd_reg[g] <= 1'b0;
					if (pop && ch_reg_target(g)) begin
						shadow[g] <= conv;
					end
					if (seq_mode && pop && ch_reg_target(g)) begin
						out_reg[g] <= conv;
						upd_reg[g] <= 1'b1;
					end
					if (state_reg == AOB_COMMIT && act_mask[g]) begin
						out_reg[g] <= shadow[g];
						upd_reg[g] <= 1'b1;
					end
				end
			end
			assign chan_out[g*aob_pkg::SAMPLE_W +: aob_pkg::SAMPLE_W] = out_reg[g];
		end
	endgenerate
	assign chan_update = upd_reg;

	// Channel targeted by the popped value
	function automatic logic ch_reg_target(input int idx);
		return seq_mode ? (nxt_ch == aob_pkg::CH_IDX_W'(idx)) : (ch_reg == aob_pkg::CH_IDX_W'(idx));
	endfunction : ch_reg_target

	// Register readback; data port reads zero
	assign bor_view = {15'h0, ovf_reg, flag_full, flag_high, flag_low, flag_empty, 3'h0,
		circ_reg, sw_clk_reg, ext_sel_reg && clk_en_reg, clk_en_reg, ext_sel_reg, size_reg};
	always_comb begin
		case (bus.bus_addr)
			aob_pkg::OFF_CONTROL: rd_mux = {27'h0, ctl_reg};
			aob_pkg::OFF_CHAN_MASK: rd_mux = {16'h0, mask_reg};
			aob_pkg::OFF_BUF_OPS: rd_mux = bor_view;
			aob_pkg::OFF_RATE: rd_mux = {16'h0, rate_reg};
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= bus.bus_rd ? rd_mux : '0;
		end
	end
	assign bus.bus_rdata = rdata_reg;
endmodule : aob_device

// [aob_pkg.sv]
package aob_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 16;
	localparam int SAMPLE_W = 16;
	localparam int WORD_W = 17;
	localparam int PTR_W = 18;
	localparam int CNT_W = 19;
	localparam int FIFO_DEPTH = 262144;
	localparam int SIZE_BASE = 3;
	localparam int RATE_W = 16;
	localparam int CH_IDX_W = 4;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CHAN_MASK = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_BUF_OPS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_RATE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SAMPLE = 8'h18;
	localparam logic [DATA_W-1:0] CHAN_MASK_RST = 32'h0000FFFF;
	localparam logic [RATE_W-1:0] RATE_RST = 16'h0085;
	localparam logic [3:0] SIZE_RST = 4'hF;
	localparam logic [SAMPLE_W-1:0] MIDRANGE = 16'h8000;
	localparam int EOF_BIT = 16;
	localparam int SIGN_BIT = 15;
	localparam int CTL_OFFSET_BIN = 0;
	localparam int CTL_BURST = 1;
	localparam int CTL_SIMUL = 2;
	localparam int CTL_TRIG_SW = 3;
	localparam int CTL_INIT = 4;
	localparam int BOR_EXT_CLK = 4;
	localparam int BOR_CLK_EN = 5;
	localparam int BOR_CLK_READY = 6;
	localparam int BOR_SW_CLK = 7;
	localparam int BOR_CIRC = 8;
	localparam int BOR_CLEAR = 11;
	localparam int BOR_EMPTY = 12;
	localparam int BOR_LOW_Q = 13;
	localparam int BOR_HIGH_Q = 14;
	localparam int BOR_FULL = 15;
	localparam int BOR_OVERFLOW = 16;
	localparam logic [3:0] HOST_DEV_ADDR = 4'h0;
	localparam logic [3:0] HOST_WRITE = 4'h4;
	localparam logic [3:0] HOST_READ = 4'h8;
	localparam logic [3:0] HOST_RESULT = 4'hC;
endpackage : aob_pkg

// [aob_if.sv]
`timescale 1ns/100ps
interface aob_if;
	logic [aob_pkg::ADDR_W-1:0] bus_addr;
	logic [aob_pkg::DATA_W-1:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [aob_pkg::DATA_W-1:0] bus_rdata;
	modport dev (
		input bus_addr,
		input bus_wdata,
		input bus_wr,
		input bus_rd,
		output bus_rdata
	);
	modport host (
		output bus_addr,
		output bus_wdata,
		output bus_wr,
		output bus_rd,
		input bus_rdata
	);
endinterface : aob_if

// [aob_host.sv]
`timescale 1ns/100ps
// Host end: turns local register accesses into single bus cycles
module aob_host (
	input wire logic clk,
	input wire logic rst,
	aob_if.host bus,
	input wire logic [3:0] addr,
	input wire logic [aob_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [aob_pkg::DATA_W-1:0] rdata
);
	logic [aob_pkg::ADDR_W-1:0] dev_addr_reg;
	logic [aob_pkg::DATA_W-1:0] result_reg;
	logic [aob_pkg::DATA_W-1:0] rdata_reg;
	logic capture_reg;
	logic issue_wr;
	logic issue_rd;

	// Local decode; repeated writes to the data port form a DMA-like burst
	// burst same address
	assign issue_wr = wr && addr == aob_pkg::HOST_WRITE;
	assign issue_rd = wr && addr == aob_pkg::HOST_READ;
	assign bus.bus_addr = dev_addr_reg;
	assign bus.bus_wdata = wdata;
	assign bus.bus_wr = issue_wr;
	assign bus.bus_rd = issue_rd;
	assign rdata = rdata_reg;

	// Target address and captured read result
	always_ff @(posedge clk) begin
		if (rst) begin
			dev_addr_reg <= '0;
			result_reg <= '0;
			capture_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			capture_reg <= issue_rd;
			if (wr && addr == aob_pkg::HOST_DEV_ADDR) begin
				dev_addr_reg <= wdata[aob_pkg::ADDR_W-1:0];
			end
			if (capture_reg) begin
				result_reg <= bus.bus_rdata;
			end
			if (rd && addr == aob_pkg::HOST_DEV_ADDR) begin
				rdata_reg <= {{(aob_pkg::DATA_W-aob_pkg::ADDR_W){1'b0}}, dev_addr_reg};
			end else if (rd && addr == aob_pkg::HOST_RESULT) begin
				rdata_reg <= result_reg;
			end else begin
				rdata_reg <= '0;
			end
		end
	end
endmodule : aob_host

// [aob_props.sv]
`timescale 1ns/100ps
// Watches the register bus between the host end and the device end
module aob_props (
	input logic clk,
	input logic rst,
	input logic [aob_pkg::ADDR_W-1:0] bus_addr,
	input logic [aob_pkg::DATA_W-1:0] bus_wdata,
	input logic bus_wr,
	input logic bus_rd,
	input logic [aob_pkg::DATA_W-1:0] bus_rdata
);
	logic [15:0] mask_reg;
	logic [15:0] mask_next;
	logic [3:0] size_reg;
	logic [3:0] size_next;
	// Request decodes
	wire rd_mask = bus_rd && bus_addr == aob_pkg::OFF_CHAN_MASK;
	wire rd_ops = bus_rd && bus_addr == aob_pkg::OFF_BUF_OPS;
	wire wr_init = bus_wr && bus_addr == aob_pkg::OFF_CONTROL && bus_wdata[aob_pkg::CTL_INIT];
	wire mapped = bus_addr == aob_pkg::OFF_CONTROL || bus_addr == aob_pkg::OFF_CHAN_MASK
		|| bus_addr == aob_pkg::OFF_BUF_OPS || bus_addr == aob_pkg::OFF_RATE || bus_addr == aob_pkg::OFF_SAMPLE;
	// Shadow copies of the channel mask and buffer size fields, back to defaults on init
	assign mask_next = wr_init ? 16'hFFFF : (bus_wr && bus_addr == aob_pkg::OFF_CHAN_MASK) ? bus_wdata[15:0] : mask_reg;
	assign size_next = wr_init ? 4'hF : (bus_wr && bus_addr == aob_pkg::OFF_BUF_OPS) ? bus_wdata[3:0] : size_reg;
	always_ff @(posedge clk) begin
		mask_reg <= rst ? 16'hFFFF : mask_next;
		size_reg <= rst ? 4'hF : size_next;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h00000000)
		else $error("read data not zero outside a read answer");
	chk_port_reads_zero: assert property (bus_rd && bus_addr == aob_pkg::OFF_SAMPLE |=> bus_rdata == 32'h00000000)
		else $error("data port read not zero");
	chk_unmapped_zero: assert property (bus_rd && !mapped |=> bus_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	chk_mask_readback: assert property (rd_mask |=> bus_rdata == {16'h0000, $past(mask_reg)})
		else $error("channel mask readback wrong");
	chk_flags_exclusive: assert property (rd_ops |=> !(bus_rdata[aob_pkg::BOR_EMPTY] && bus_rdata[aob_pkg::BOR_FULL]))
		else $error("empty and full together");
	chk_flag_quarters: assert property (rd_ops |=> (!bus_rdata[aob_pkg::BOR_EMPTY] || bus_rdata[aob_pkg::BOR_LOW_Q])
		&& (!bus_rdata[aob_pkg::BOR_FULL] || bus_rdata[aob_pkg::BOR_HIGH_Q]))
		else $error("quarter flags disagree with empty or full");
	chk_size_readback: assert property (rd_ops |=> bus_rdata[3:0] == $past(size_reg))
		else $error("buffer size readback wrong");
	chk_strobes_apart: assert property (!(bus_wr && bus_rd))
		else $error("write and read strobes together");
	cover property (rd_ops ##1 bus_rdata[aob_pkg::BOR_FULL]);
	cover property (rd_mask ##1 bus_rdata[15:0] == 16'h0000);
	cover property (bus_wr && bus_addr == aob_pkg::OFF_SAMPLE && bus_wdata[aob_pkg::EOF_BIT]);
endmodule : aob_props

// [tb.sv]
`timescale 1ns/100ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module tb;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} aob_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] h_addr = 4'h0;
	logic [31:0] h_wdata = 32'h00000000;
	logic h_wr = 1'b0;
	logic h_rd = 1'b0;
	logic ext_clk = 1'b0;
	logic trig = 1'b0;
	logic [31:0] h_rdata;
	logic [255:0] chan_out;
	logic [15:0] chan_update;
	logic [31:0] r;
	int errors = 0;
	int tests_run = 0;
	int upd_ch[$];
	logic [15:0] upd_val[$];
	time upd_t[$];
	aob_row_t rows [5] = '{'{8'h04, 1'b1, 32'hFFFF1234, 32'h00001234}, '{8'h04, 1'b1, 32'h00000000, 32'h00000000},
		'{8'h18, 1'b0, 32'h00000000, 32'h00000000}, '{8'h08, 1'b0, 32'h00000000, 32'h00000000},
		'{8'h14, 1'b0, 32'h00000000, 32'h00000000}};
	aob_if bus_if ();
	aob_host aob_host_i (.clk(clk), .rst(rst), .bus(bus_if), .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd),
		.rdata(h_rdata));
	aob_device aob_device_i (.clk(clk), .rst(rst), .bus(bus_if), .ext_clk_pin(ext_clk), .trig_pin(trig),
		.chan_out(chan_out), .chan_update(chan_update));
	aob_props aob_props_i (.clk(clk), .rst(rst), .bus_addr(bus_if.bus_addr), .bus_wdata(bus_if.bus_wdata),
		.bus_wr(bus_if.bus_wr), .bus_rd(bus_if.bus_rd), .bus_rdata(bus_if.bus_rdata));
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Records each channel update with its value and time
	always @(posedge clk) begin
		for (int n = 0; n < 16; n++) begin
			if (!rst && chan_update[n] === 1'b1) begin
				upd_ch.push_back(n);
				upd_val.push_back(chan_out[16*n +: 16]);
				upd_t.push_back($time);
			end
		end
	end
	// One strobe cycle on the host user port
	task automatic host_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		h_addr <= a;
		h_wdata <= d;
		h_wr <= 1'b1;
		@(posedge clk);
		h_wr <= 1'b0;
	endtask : host_wr
	task automatic host_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		h_addr <= a;
		h_rd <= 1'b1;
		@(posedge clk);
		h_rd <= 1'b0;
		#1;
		d = h_rdata;
	endtask : host_rd
	// Device register access through the host end
	task automatic dev_wr(input logic [7:0] a, input logic [31:0] d);
		host_wr(aob_pkg::HOST_DEV_ADDR, {24'h000000, a});
		host_wr(aob_pkg::HOST_WRITE, d);
	endtask : dev_wr
	task automatic dev_rd(input logic [7:0] a, output logic [31:0] d);
		host_wr(aob_pkg::HOST_DEV_ADDR, {24'h000000, a});
		host_wr(aob_pkg::HOST_READ, 32'h00000000);
		repeat (3) @(posedge clk);
		host_rd(aob_pkg::HOST_RESULT, d);
	endtask : dev_rd
	// Bounded wait for a number of updates, then a margin for stray ones
	task automatic wait_upd(input int n);
		int k;
		k = 0;
		while (upd_ch.size() < n && k < 400) begin
			@(posedge clk);
			k++;
		end
		repeat (20) @(posedge clk);
	endtask : wait_upd
	task automatic final_report;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		for (int n = 0; n < 16; n++) `CHECK(chan_out[16*n +: 16], aob_pkg::MIDRANGE)
		dev_rd(aob_pkg::OFF_CHAN_MASK, r);
		`CHECK(r, aob_pkg::CHAN_MASK_RST)
		dev_rd(aob_pkg::OFF_BUF_OPS, r);
		`CHECK(r, 32'h0000300F)
		foreach (rows[i]) begin
			if (rows[i].w) dev_wr(rows[i].a, rows[i].d);
			dev_rd(rows[i].a, r);
			`CHECK(r, rows[i].e)
		end
		host_rd(aob_pkg::HOST_DEV_ADDR, r);
		`CHECK(r, 32'h00000014)
		// fill an eight-entry buffer, upper bits junk, one extra write
		dev_wr(aob_pkg::OFF_CHAN_MASK, 32'h00000005);
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000000);
		dev_wr(aob_pkg::OFF_RATE, 32'h00000003);
		for (int i = 0; i < 9; i++) dev_wr(aob_pkg::OFF_SAMPLE, {15'h7FFF, 1'b0, 4'(i + 1), 12'h0A5});
		dev_rd(aob_pkg::OFF_SAMPLE, r);
		`CHECK(r, 32'h00000000)
		dev_rd(aob_pkg::OFF_BUF_OPS, r);
		`CHECK(r[16:0], 17'h1C000)
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000020);
		wait_upd(8);
		`CHECK(upd_ch.size(), 8)
		for (int i = 0; i < 8; i++) begin
			`CHECK(upd_ch[i], (i % 2) * 2)
			`CHECK(upd_val[i], {4'(i + 1), 12'h0A5})
		end
		upd_ch.delete();
		upd_val.delete();
		dev_wr(aob_pkg::OFF_CHAN_MASK, 32'h00000001);
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h0000AAAA);
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h0001BBBB);
		wait_upd(2);
		`CHECK(upd_ch.size(), 2)
		`CHECK(upd_ch[1], 0)
		`CHECK(upd_val[1], 16'hBBBB)
		`CHECK(chan_out[47:32], 16'h80A5)
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000800);
		upd_ch.delete();
		upd_val.delete();
		upd_t.delete();
		dev_wr(aob_pkg::OFF_CHAN_MASK, 32'h00000005);
		dev_wr(aob_pkg::OFF_CONTROL, 32'h00000005);
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h00000101);
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h00010202);
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000120);
		wait_upd(4);
		for (int i = 0; i < 4; i++) `CHECK(upd_val[i], (i % 2) ? 16'h0202 : 16'h0101)
		`CHECK(upd_t[0], upd_t[1])
		`CHECK(upd_t[2], upd_t[3])
		// burst waits for the trigger, then one frame
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000800);
		dev_wr(aob_pkg::OFF_CHAN_MASK, 32'h00000001);
		upd_ch.delete();
		upd_val.delete();
		dev_wr(aob_pkg::OFF_CONTROL, 32'h00000003);
		// one-channel groups, frame end on the second
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h00000011);
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h00010022);
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h00000033);
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000020);
		wait_upd(0);
		`CHECK(upd_ch.size(), 0)
		@(posedge clk);
		trig <= 1'b1;
		repeat (4) @(posedge clk);
		trig <= 1'b0;
		wait_upd(2);
		`CHECK(upd_ch.size(), 2)
		`CHECK(upd_val[1], 16'h0022)
		// pin and software clock, two's complement input
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000800);
		dev_wr(aob_pkg::OFF_CONTROL, 32'h00000000);
		upd_ch.delete();
		upd_val.delete();
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h00007FFF);
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h00000030);
		wait_upd(0);
		`CHECK(upd_ch.size(), 0)
		@(posedge clk);
		ext_clk <= 1'b1;
		repeat (4) @(posedge clk);
		ext_clk <= 1'b0;
		wait_upd(1);
		`CHECK(upd_val[0], 16'hFFFF)
		dev_wr(aob_pkg::OFF_SAMPLE, 32'h00008000);
		dev_wr(aob_pkg::OFF_BUF_OPS, 32'h000000B0);
		wait_upd(2);
		`CHECK(upd_ch.size(), 2)
		`CHECK(upd_val[1], 16'h0000)
		// soft init brings outputs back to midrange
		dev_wr(aob_pkg::OFF_CONTROL, 32'h00000010);
		repeat (2) @(posedge clk);
		#1;
		`CHECK(chan_out[15:0], aob_pkg::MIDRANGE)
		// reset in mid-run restores register defaults
		dev_wr(aob_pkg::OFF_CHAN_MASK, 32'h00000003);
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		dev_rd(aob_pkg::OFF_CHAN_MASK, r);
		`CHECK(r, aob_pkg::CHAN_MASK_RST)
		dev_rd(aob_pkg::OFF_BUF_OPS, r);
		`CHECK(r, 32'h0000300F)
		final_report();
	end
	// Watchdog
	initial begin
		#2000000;
		errors++;
		final_report();
	end
endmodule : tb
